// file: design/t1_esf_perf_report_gen.sv
// Performance report generator with its bit FIFO toward the data-link slot.
`timescale 1ns/1ps
`default_nettype none

module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             inValid,
    output var  logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    output var  logic             outValid,
    input  wire logic             outReady,
    output var  logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR   = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wrPtr;
        logic [PW-1:0]               rdPtr;
        logic [CW-1:0]               count;
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        doPush;
    logic        doPop;

    always_comb begin
        s_d      = s_q;
        inReady  = (s_q.count != FULL_COUNT);
        outValid = (s_q.count != '0);
        outData  = s_q.mem[s_q.rdPtr];
        doPush   = inValid && inReady;
        doPop    = outValid && outReady;
        if (doPush) begin
            s_d.mem[s_q.wrPtr] = inData;
            s_d.wrPtr = (s_q.wrPtr == LAST_PTR) ? '0 : s_q.wrPtr + PW'(1);
        end
        if (doPop) begin
            s_d.rdPtr = (s_q.rdPtr == LAST_PTR) ? '0 : s_q.rdPtr + PW'(1);
        end
        if (doPush && !doPop) begin
            s_d.count = s_q.count + CW'(1);
        end else if (doPop && !doPush) begin
            s_d.count = s_q.count - CW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : bit_fifo

////////////////////////////////////////////////////////////////////////////////

module t1_esf_perf_report_gen
    import perf_report_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic secondTick,
    input  wire logic t1Mode,
    input  wire logic esfFraming,
    input  wire logic autoReportEnable,
    input  wire logic cmdRespValue,
    input  wire logic reservedPosValue,
    input  wire logic user1PosValue,
    input  wire logic user2PosValue,
    input  wire logic loopbackPosValue,
    input  wire logic lineViolation,
    input  wire logic crcError,
    input  wire logic frameBitError,
    input  wire logic severeFrameError,
    input  wire logic slipEvent,
    input  wire logic dlSlot,
    output var  logic facilityLinkBits,
    output var  logic facilityLinkValid,
    output var  logic reportBusy
);
    // Pair layout: grade[5:0] (six..one), severe, frame, violation, slip, seq[1:0].
    typedef struct packed {
        gen_state_t                       state;
        logic [3:0]                       octetIdx;
        logic [2:0]                       bitIdx;
        logic [2:0]                       onesRun;
        logic [15:0]                      fcs;
        logic [1:0]                       seqCount;
        logic [CNT_W-1:0]                 crcCount;
        logic                             violSeen;
        logic                             frameSeen;
        logic                             severeSeen;
        logic                             slipSeen;
        logic [PAIR_COUNT-1:0][PAIR_W-1:0] pairs;
        logic [PAIR_COUNT-1:0][PAIR_W-1:0] snap;
        logic                             linkBit;
        logic                             linkValid;
        logic                             busy;
    } gen_reg_t;

    gen_reg_t s_q;
    gen_reg_t s_d;

    logic       modeOk;
    logic       startReport;
    logic       pushValid;
    logic       pushReady;
    logic       pushData;
    logic       needStuff;
    logic       curBit;
    logic [7:0] curByte;
    logic       fifoValid;
    logic       fifoData;

    function automatic logic [5:0] crcGrade(input logic [CNT_W-1:0] n);
        logic [5:0] g;
        g = 6'h00;
        if (n == GRADE_ONE) begin
            g[0] = 1'b1;
        end else if (n > GRADE_ONE && n <= GRADE_TWO_MAX) begin
            g[1] = 1'b1;
        end else if (n > GRADE_TWO_MAX && n <= GRADE_THREE_MAX) begin
            g[2] = 1'b1;
        end else if (n > GRADE_THREE_MAX && n <= GRADE_FOUR_MAX) begin
            g[3] = 1'b1;
        end else if (n > GRADE_FOUR_MAX && n <= GRADE_FIVE_MAX) begin
            g[4] = 1'b1;
        end else if (n > GRADE_SIX_ABOVE) begin
            g[5] = 1'b1;
        end
        return g; // R10 R11
    endfunction : crcGrade

    function automatic logic [15:0] fcsStep(input logic [15:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        return fb ? ((c >> 1) ^ FCS_POLY_REV) : (c >> 1); // R13
    endfunction : fcsStep

    // Odd octet, bit 8 down to 1: G3 LV G4 U1 U2 G5 SL G6; even: FE SE LB G1 R G2 Nm Ni.
    function automatic logic [7:0] pairOctet(input logic [PAIR_W-1:0] p, input logic odd,
                                             input logic r, input logic u1, input logic u2,
                                             input logic lb);
        if (odd) begin
            return {p[8], p[3], p[9], u1, u2, p[10], p[2], p[11]}; // R9 R7
        end
        return {p[4], p[5], lb, p[6], r, p[7], p[1], p[0]}; // R9 R7 R8
    endfunction : pairOctet

    logic [1:0] pairSel;
    assign pairSel = 2'(({1'b0, s_q.octetIdx} - {1'b0, OCT_PAIR_FIRST}) >> 1);

    always_comb begin
        case (s_q.octetIdx)
            OCT_SAPI:   curByte = SAPI_BASE | (8'(cmdRespValue) << SAPI_CR_POS); // R5 R7
            OCT_TEI:    curByte = TEI_OCTET; // R5
            OCT_CTRL:   curByte = CTRL_OCTET; // R5
            OCT_FCS_LO: curByte = ~s_q.fcs[7:0]; // R13
            OCT_FCS_HI: curByte = ~s_q.fcs[15:8]; // R13
            OCT_OPEN,
            OCT_CLOSE:  curByte = FLAG_OCTET; // R5
            default:    curByte = pairOctet(s_q.snap[pairSel], s_q.octetIdx[0],
                                            reservedPosValue, user1PosValue,
                                            user2PosValue, loopbackPosValue);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        s_d         = s_q;
        modeOk      = t1Mode && esfFraming;
        startReport = secondTick && autoReportEnable && modeOk && (s_q.state == GEN_IDLE);
        curBit      = curByte[s_q.bitIdx]; // R6
        needStuff   = (s_q.onesRun == STUFF_RUN);
        pushValid   = (s_q.state == GEN_SEND);
        pushData    = needStuff ? 1'b0 : curBit; // R13

        // An event landing on the tick counts toward the new interval, so none is lost.
        if (secondTick) begin
            s_d.pairs      = {s_q.pairs[PAIR_COUNT-2:0],
                              {crcGrade(s_q.crcCount), s_q.severeSeen, s_q.frameSeen,
                               s_q.violSeen, s_q.slipSeen, s_q.seqCount}}; // R14 R12
            s_d.crcCount   = crcError ? GRADE_ONE : '0; // R14
            s_d.violSeen   = lineViolation; // R14
            s_d.frameSeen  = frameBitError;
            s_d.severeSeen = severeFrameError;
            s_d.slipSeen   = slipEvent;
        end else begin
            if (crcError && s_q.crcCount != CNT_MAX) begin
                s_d.crcCount = s_q.crcCount + CNT_W'(1); // R2 R3
            end
            s_d.violSeen   = s_q.violSeen | lineViolation; // R2 R3
            s_d.frameSeen  = s_q.frameSeen | frameBitError;
            s_d.severeSeen = s_q.severeSeen | severeFrameError;
            s_d.slipSeen   = s_q.slipSeen | slipEvent;
        end

        if (s_q.state == GEN_SEND && pushReady) begin
            if (needStuff) begin
                s_d.onesRun = '0;
            end else begin
                if (s_q.octetIdx >= OCT_SAPI && s_q.octetIdx <= OCT_FCS_HI) begin
                    s_d.onesRun = curBit ? s_q.onesRun + 3'h1 : 3'h0; // R13
                end
                if (s_q.octetIdx >= OCT_SAPI && s_q.octetIdx <= OCT_PAIR_LAST) begin
                    s_d.fcs = fcsStep(s_q.fcs, curBit); // R13
                end
                s_d.bitIdx = s_q.bitIdx + 3'h1; // R6
                if (s_q.bitIdx == LAST_BIT) begin
                    s_d.octetIdx = s_q.octetIdx + 4'h1; // R6
                    if (s_q.octetIdx == OCT_CLOSE) begin
                        s_d.state = GEN_IDLE; // R5
                    end
                end
            end
        end

        if (startReport) begin
            s_d.state    = GEN_SEND; // R4
            s_d.octetIdx = OCT_OPEN;
            s_d.bitIdx   = '0;
            s_d.onesRun  = '0;
            s_d.fcs      = FCS_INIT;
            s_d.snap     = s_d.pairs;
            s_d.seqCount = s_q.seqCount + 2'h1; // R8
        end
        if (!modeOk) begin
            s_d.state = GEN_IDLE; // R1
        end

        // Idle slots carry marks; a report needs far less than a second of slots.
        s_d.linkValid = dlSlot && fifoValid;
        if (dlSlot) begin
            s_d.linkBit = fifoValid ? fifoData : 1'b1; // R4
        end
        s_d.busy = (s_d.state == GEN_SEND) || fifoValid;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_q         <= '0;
            s_q.fcs     <= FCS_INIT;
            s_q.linkBit <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    bit_fifo #(.WIDTH(1), .DEPTH(DEPTH)) u_fifo (
        .mclk     (mclk),
        .rstn     (rstn),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushData),
        .outValid (fifoValid),
        .outReady (dlSlot),
        .outData  (fifoData)
    );

    assign facilityLinkBits  = s_q.linkBit;
    assign facilityLinkValid = s_q.linkValid;
    assign reportBusy        = s_q.busy;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_idle_wrong_mode: assert property (!(t1Mode && esfFraming) |=> s_q.state == GEN_IDLE) // R1
        else $error("generator active outside T1 ESF");
    a_crc_count_up: assert property (!secondTick && crcError && s_q.crcCount != CNT_MAX // R2
        |=> s_q.crcCount == $past(s_q.crcCount) + CNT_W'(1))
        else $error("crc counter missed an event");
    a_slip_sticky: assert property (slipEvent |=> s_q.slipSeen) // R3
        else $error("slip event lost");
    a_report_start: assert property (secondTick && autoReportEnable && t1Mode && esfFraming // R4
        && s_q.state == GEN_IDLE |=> s_q.state == GEN_SEND && s_q.octetIdx == OCT_OPEN)
        else $error("report did not start on tick");
    a_close_ends: assert property (s_q.state == GEN_SEND && s_q.octetIdx == OCT_CLOSE // R5
        && s_q.bitIdx == LAST_BIT && pushReady && !needStuff |=> s_q.state == GEN_IDLE)
        else $error("report did not end after closing flag");
    a_bit_order: assert property (s_q.state == GEN_SEND && pushReady && !needStuff // R6
        && t1Mode && esfFraming && !secondTick |=> s_q.bitIdx == $past(s_q.bitIdx) + 3'h1)
        else $error("bit index did not advance");
    a_seq_advance: assert property (startReport // R8
        |=> s_q.seqCount == $past(s_q.seqCount) + 2'h1)
        else $error("sequence count did not advance");
    // The end grades are held against the thresholds directly; the stream check covers the rest.
    a_grade_capture: assert property (secondTick // R11
        |=> s_q.pairs[0][11] == ($past(s_q.crcCount) > GRADE_SIX_ABOVE)
            && s_q.pairs[0][6] == ($past(s_q.crcCount) == GRADE_ONE)
            && $onehot0(s_q.pairs[0][11:6]))
        else $error("crc grade wrong");
    a_stuff_zero: assert property (s_q.state == GEN_SEND && s_q.onesRun == STUFF_RUN // R13
        |-> pushData == 1'b0)
        else $error("no zero after five ones");
    a_pair_shift: assert property (secondTick |=> s_q.pairs[1] == $past(s_q.pairs[0])) // R14
        else $error("older pair not shifted");
    a_snap_at_start: assert property (startReport |=> s_q.snap == s_q.pairs) // R9
        else $error("report snapshot differs from captured pairs");

    // Data-link hand-over: a slot takes one queued bit, or shows a mark when nothing is queued.
    a_slot_carries: assert property (dlSlot && fifoValid // R4
        |=> s_q.linkValid && s_q.linkBit == $past(fifoData))
        else $error("slot bit not handed over");
    a_idle_marks: assert property (dlSlot && !fifoValid |=> s_q.linkBit && !s_q.linkValid) // R4
        else $error("empty slot not sent as mark");
    a_no_start_off: assert property (!autoReportEnable && s_q.state == GEN_IDLE // R4
        |=> s_q.state == GEN_IDLE)
        else $error("report started while disabled");
    a_busy_shown: assert property (s_q.state == GEN_SEND |-> s_q.busy) // R4
        else $error("busy low while sending");
    a_cr_position: assert property (s_q.state == GEN_SEND && s_q.octetIdx == OCT_SAPI // R7
        && s_q.bitIdx == 3'(SAPI_CR_POS) && !needStuff |-> pushData == cmdRespValue)
        else $error("command/response bit wrong");
    a_seq_hold: assert property (!startReport |=> s_q.seqCount == $past(s_q.seqCount)) // R8
        else $error("sequence count moved without a report");
    a_frame_sticky: assert property (frameBitError |=> s_q.frameSeen) // R12
        else $error("framing error lost");
    a_viol_sticky: assert property (lineViolation |=> s_q.violSeen) // R12
        else $error("line violation lost");
    a_severe_sticky: assert property (severeFrameError |=> s_q.severeSeen) // R12
        else $error("severe framing error lost");
    a_fcs_seed: assert property (startReport |=> s_q.fcs == FCS_INIT) // R13
        else $error("check sequence not seeded");
    a_run_bounded: assert property (s_q.onesRun <= STUFF_RUN) // R13
        else $error("ones run passed the stuffing limit");
    a_tick_clears: assert property (secondTick && !crcError |=> s_q.crcCount == '0) // R14
        else $error("crc counter not cleared at tick");
endmodule : t1_esf_perf_report_gen

`default_nettype wire

// file: design/perf_report_pkg.sv
// Constants and types for the once-per-second performance report generator.
// Summary of operation
// [R1] Reports go out only in T1/J1 mode with extended-superframe framing; otherwise idle.
// [R2] Count line violations, CRC-6 errors, framing-bit errors, severe framing errors, slips.
// [R3] Violations from decoder, CRC and framing from frame processor, slips from store.
// [R4] With auto report enabled, one report per second onto the data-link bits.
// [R5] Fifteen octets: flag 01111110, SAPI with C/R, TEI, control, fixed values.
// [R6] Bit 1 of each octet first, bit 8 last; octets in ascending order.
// [R7] C/R, R, U1, U2 and loopback positions come from five control inputs.
// [R8] Sequence bits in even performance octets carry a modulo-4 report counter.
// [R9] Octets 5 to 12 are four pairs with the fixed odd and even layouts.
// [R10] Event bits encode the counts and read zero when no threshold is met.
// [R11] CRC count sets one grade bit: 1, 2-5, 6-10, 11-100, 101-319, above 320.
// [R12] Severe, framing, violation and slip flags set when at least one event occurred.
// [R13] Octets 13-14 hold a 16-bit FCS over octets 2-12; zero insertion between flags.
// [R14] Each second capture counts into newest pair, shift older pairs, clear counters.
package perf_report_pkg;

    localparam logic [7:0]  FLAG_OCTET      = 8'h7e;
    localparam logic [7:0]  SAPI_BASE       = 8'h38;
    localparam int          SAPI_CR_POS     = 1;
    localparam logic [7:0]  TEI_OCTET       = 8'h01;
    localparam logic [7:0]  CTRL_OCTET      = 8'h03;

    localparam logic [3:0]  OCT_OPEN        = 4'h1;
    localparam logic [3:0]  OCT_SAPI        = 4'h2;
    localparam logic [3:0]  OCT_TEI         = 4'h3;
    localparam logic [3:0]  OCT_CTRL        = 4'h4;
    localparam logic [3:0]  OCT_PAIR_FIRST  = 4'h5;
    localparam logic [3:0]  OCT_PAIR_LAST   = 4'hc;
    localparam logic [3:0]  OCT_FCS_LO      = 4'hd;
    localparam logic [3:0]  OCT_FCS_HI      = 4'he;
    localparam logic [3:0]  OCT_CLOSE       = 4'hf;
    localparam logic [2:0]  LAST_BIT        = 3'h7;

    localparam int          CNT_W           = 9;
    localparam logic [8:0]  CNT_MAX         = 9'h1ff;
    localparam logic [8:0]  GRADE_ONE       = 9'h001;
    localparam logic [8:0]  GRADE_TWO_MAX   = 9'h005;
    localparam logic [8:0]  GRADE_THREE_MAX = 9'h00a;
    localparam logic [8:0]  GRADE_FOUR_MAX  = 9'h064;
    localparam logic [8:0]  GRADE_FIVE_MAX  = 9'h13f;
    localparam logic [8:0]  GRADE_SIX_ABOVE = 9'h140;

    localparam logic [15:0] FCS_INIT        = 16'hffff;
    localparam logic [15:0] FCS_POLY_REV    = 16'h8408;
    localparam logic [2:0]  STUFF_RUN       = 3'h5;

    localparam int          PAIR_COUNT      = 4;
    localparam int          PAIR_W          = 12;
    localparam int          FIFO_DEPTH      = 8;

    typedef enum logic [0:0] {
        GEN_IDLE = 1'b0,
        GEN_SEND = 1'b1
    } gen_state_t;

endpackage : perf_report_pkg

// file: bench/frame_gen_model.sv
// Behavioural transmit frame generator that offers data-link slots and collects report bits.
`timescale 1ns/1ps
`default_nettype none

module frame_gen_model (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [3:0] slotGap,
    input  wire logic       facilityLinkBits,
    input  wire logic       facilityLinkValid,
    output var  logic       dlSlot
);
    logic [3:0] gapCnt;
    logic       bitQ[$];

    // Slots come at a steady spacing whether or not a report is pending, as a superframe would.
    always @(posedge mclk) begin
        if (!rstn) begin
            gapCnt <= 4'h0;
            dlSlot <= 1'b0;
        end else begin
            dlSlot <= (gapCnt == 4'h0);
            gapCnt <= (gapCnt >= slotGap) ? 4'h0 : gapCnt + 4'h1;
        end
        if (facilityLinkValid === 1'b1) begin
            bitQ.push_back(facilityLinkBits);
        end
    end
endmodule : frame_gen_model

`default_nettype wire

// file: bench/tb_top.sv
// Self-checking testbench for the performance report generator.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import perf_report_pkg::*;
    logic mclk = 0, rstn = 0, secondTick = 0, t1Mode = 1, esfFraming = 1, autoReportEnable = 1;
    logic [4:0] ctl = 5'h00;
    logic [4:0] ev = 5'h00;
    logic [3:0] slotGap = 4'h0;
    logic dlSlot, facilityLinkBits, facilityLinkValid, reportBusy;
    logic [11:0] pairs[4];
    logic [1:0] seq = 2'h0;
    int err_count = 0;
    int samples_checked = 0;

    always #4 mclk = ~mclk;

    t1_esf_perf_report_gen dut_u (.mclk(mclk), .rstn(rstn), .secondTick(secondTick),
        .t1Mode(t1Mode), .esfFraming(esfFraming), .autoReportEnable(autoReportEnable),
        .cmdRespValue(ctl[4]), .reservedPosValue(ctl[3]), .user1PosValue(ctl[2]),
        .user2PosValue(ctl[1]), .loopbackPosValue(ctl[0]), .lineViolation(ev[4]),
        .crcError(ev[3]), .frameBitError(ev[2]), .severeFrameError(ev[1]), .slipEvent(ev[0]),
        .dlSlot(dlSlot), .facilityLinkBits(facilityLinkBits),
        .facilityLinkValid(facilityLinkValid), .reportBusy(reportBusy));
    frame_gen_model fg_u (.mclk(mclk), .rstn(rstn), .slotGap(slotGap),
        .facilityLinkBits(facilityLinkBits), .facilityLinkValid(facilityLinkValid),
        .dlSlot(dlSlot));

    ////////////////////////////////////////////////////////////////////////////////

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    task automatic chk(string what, logic [15:0] expv, logic [15:0] got);
        samples_checked++;
        if (got !== expv) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, expv, got);
        end
    endtask : chk

    task automatic step(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    // Pair layout: {g6, g5, g4, g3, g2, g1, lv, fe, se, sl, seq}.
    function automatic logic [11:0] make_pair(int n, logic [3:0] fl, logic [1:0] s);
        return {n > 320, n > 100 && n <= 319, n > 10 && n <= 100, n > 5 && n <= 10,
                n > 1 && n <= 5, n == 1, fl, s};
    endfunction : make_pair

    // Flags are {lv, fe, se, sl}; all of them pulse together in the first cycle.
    task automatic events(int crcN, logic [3:0] fl);
        for (int i = 0; i < ((crcN > 0) ? crcN : 1); i++) begin
            ev = {fl[3] && i == 0, i < crcN, fl[2] && i == 0, fl[1] && i == 0, fl[0] && i == 0};
            step(1);
        end
        ev = 5'h00;
        step(1);
    endtask : events

    task automatic check_stream();
        logic [7:0] oct[14];
        logic exq[$];
        logic [15:0] fcs;
        int ones;
        logic b;
        logic fb;
        string what;
        oct[0] = FLAG_OCTET;
        oct[1] = SAPI_BASE | (8'(ctl[4]) << SAPI_CR_POS);
        oct[2] = TEI_OCTET;
        oct[3] = CTRL_OCTET;
        for (int p = 0; p < 4; p++) begin
            oct[4+2*p] = {pairs[p][8], pairs[p][5], pairs[p][9], ctl[2], ctl[1],
                          pairs[p][10], pairs[p][2], pairs[p][11]};
            oct[5+2*p] = {pairs[p][4], pairs[p][3], ctl[0], pairs[p][6], ctl[3],
                          pairs[p][7], pairs[p][1], pairs[p][0]};
        end
        fcs = 16'hffff;
        for (int o = 1; o < 12; o++) for (int i = 0; i < 8; i++) begin
            fb = fcs[0] ^ oct[o][i];
            fcs = fcs >> 1;
            if (fb) fcs = fcs ^ 16'h8408;
        end
        oct[12] = ~fcs[7:0];
        oct[13] = ~fcs[15:8];
        for (int i = 0; i < 8; i++) exq.push_back(oct[0][i]);
        ones = 0;
        for (int o = 1; o < 14; o++) for (int i = 0; i < 8; i++) begin
            b = oct[o][i];
            exq.push_back(b);
            ones = b ? ones + 1 : 0;
            if (ones == 5) begin
                exq.push_back(1'b0);
                ones = 0;
            end
        end
        for (int i = 0; i < 8; i++) exq.push_back(oct[0][i]);
        chk("stream length", 16'(exq.size()), 16'(fg_u.bitQ.size()));
        if (exq.size() == fg_u.bitQ.size()) begin
            foreach (exq[i]) begin
                what = $sformatf("stream bit %0d", i);
                chk(what, 16'(exq[i]), 16'(fg_u.bitQ[i]));
            end
        end
    endtask : check_stream

    // One second boundary; the model captures the interval and, for a report, checks it.
    task automatic tick(int crcN, logic [3:0] fl, bit rpt);
        int n;
        fg_u.bitQ.delete();
        secondTick = 1;
        step(1);
        secondTick = 0;
        for (int p = 3; p > 0; p--) pairs[p] = pairs[p-1];
        pairs[0] = make_pair(crcN, fl, seq);
        step(1);
        chk("busy after tick", 16'(rpt), 16'(reportBusy));
        if (!rpt) begin
            step(200);
            chk("idle bit count", 16'h0000, 16'(fg_u.bitQ.size()));
            chk("idle line level", 16'h0001, 16'(facilityLinkBits));
            return;
        end
        seq = seq + 2'h1;
        n = 0;
        while (reportBusy !== 1'b0) begin
            step(1);
            n++;
            if (n > 3000) begin
                err_count++;
                $display("Error report drain expected done seen busy");
                print_verdict();
            end
        end
        step(4 * (int'(slotGap) + 2));
        check_stream();
    endtask : tick

    ////////////////////////////////////////////////////////////////////////////////

    task automatic sc_grades();
        int counts[12] = '{0, 1, 2, 5, 6, 10, 11, 100, 101, 319, 320, 321};
        ctl = 5'h15;
        foreach (counts[i]) begin
            events(counts[i], 4'h0);
            tick(counts[i], 4'h0, 1);
        end
    endtask : sc_grades

    // Each flag alone, with a slow slot rate so the bit FIFO fills and stalls.
    task automatic sc_flags();
        slotGap = 4'h3;
        for (int k = 0; k < 4; k++) begin
            ctl = 5'(5'h01 << k) ^ 5'h0a;
            events(0, 4'(4'h1 << k));
            tick(0, 4'(4'h1 << k), 1);
        end
        slotGap = 4'h0;
    endtask : sc_flags

    // Any missing condition keeps it silent, yet the interval still enters the pairs.
    task automatic sc_idle();
        logic [2:0] modes[3] = '{3'h3, 3'h5, 3'h6};
        foreach (modes[i]) begin
            {t1Mode, esfFraming, autoReportEnable} = modes[i];
            events(3, 4'hf);
            tick(3, 4'hf, 0);
        end
        {t1Mode, esfFraming, autoReportEnable} = 3'h7;
        ctl = 5'h1f;
        events(0, 4'h0);
        tick(0, 4'h0, 1);
    endtask : sc_idle

    initial begin
        foreach (pairs[i]) pairs[i] = 12'h000;
        step(20);
        rstn = 1;
        step(2);
        sc_grades();
        sc_flags();
        sc_idle();
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
